// *** rtl/ppr_pkg.sv ***
/*
 * Shared constants and types for the peripheral pin remap fabric.
 * Assumes one 20 MHz clock domain and plain-port register access.
 */
package ppr_pkg;

	localparam int PPR_PIN_COUNT = 26;
	localparam int PPR_IN_COUNT  = 19;
	localparam int PPR_FIELD_W   = 5;
	localparam int PPR_ADDR_W    = 7;
	localparam int PPR_DATA_W    = 8;
	localparam int PPR_SRC_COUNT = 8;

	// register addresses on the plain access port
	localparam logic [PPR_ADDR_W-1:0] PPR_ADDR_OSC     = 7'h00;
	localparam logic [PPR_ADDR_W-1:0] PPR_ADDR_IN_BASE = 7'h20;
	localparam logic [PPR_ADDR_W-1:0] PPR_ADDR_OUT_BASE = 7'h40;

	// oscillator control low byte: keys and lock position
	localparam logic [PPR_DATA_W-1:0] PPR_KEY_FIRST  = 8'h46;
	localparam logic [PPR_DATA_W-1:0] PPR_KEY_SECOND = 8'h57;
	localparam int                    PPR_LOCK_BIT   = 6;
	localparam logic                  PPR_LOCK_RST   = 1'b0;

	// field codes
	localparam logic [PPR_FIELD_W-1:0] PPR_IN_TIE_GND  = 5'h1f;
	localparam logic [PPR_FIELD_W-1:0] PPR_IN_MAP_RST  = 5'h1f;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_MAP_RST = 5'h00;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_NULL    = 5'h00;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_U_TX    = 5'h03;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_U_RTS   = 5'h04;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_SPI_DO  = 5'h07;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_SPI_CK  = 5'h08;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_SPI_SS  = 5'h09;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_CMP1    = 5'h12;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_CMP2    = 5'h13;
	localparam logic [PPR_FIELD_W-1:0] PPR_OUT_ENC_DIR = 5'h1a;

	// bit positions of the peripheral output source vector
	localparam int PPR_SRC_U_TX    = 0;
	localparam int PPR_SRC_U_RTS   = 1;
	localparam int PPR_SRC_SPI_DO  = 2;
	localparam int PPR_SRC_SPI_CK  = 3;
	localparam int PPR_SRC_SPI_SS  = 4;
	localparam int PPR_SRC_CMP1    = 5;
	localparam int PPR_SRC_CMP2    = 6;
	localparam int PPR_SRC_ENC_DIR = 7;

	// peripheral input indices (field index and periph_in_o bit)
	localparam int PPR_IN_EXT_INTERRUPT_ONE = 0;
	localparam int PPR_IN_EXT_INTERRUPT_TWO = 1;
	localparam int PPR_IN_TIMER_TWO_CLOCK   = 2;
	localparam int PPR_IN_TIMER_THREE_CLOCK = 3;
	localparam int PPR_IN_CAPTURE_ONE       = 4;
	localparam int PPR_IN_CAPTURE_TWO       = 5;
	localparam int PPR_IN_CAPTURE_SEVEN     = 6;
	localparam int PPR_IN_CAPTURE_EIGHT     = 7;
	localparam int PPR_IN_COMPARE_FAULT_A   = 8;
	localparam int PPR_IN_PWM_FAULT_ONE     = 9;
	localparam int PPR_IN_PWM_FAULT_TWO     = 10;
	localparam int PPR_IN_ENCODER_PHASE_A   = 11;
	localparam int PPR_IN_ENCODER_PHASE_B   = 12;
	localparam int PPR_IN_ENCODER_INDEX     = 13;
	localparam int PPR_IN_UART_RECEIVE      = 14;
	localparam int PPR_IN_UART_CLEAR_TO_SEND = 15;
	localparam int PPR_IN_SPI_DATA          = 16;
	localparam int PPR_IN_SPI_CLOCK         = 17;
	localparam int PPR_IN_SPI_SELECT        = 18;

	typedef logic [PPR_IN_COUNT-1:0][PPR_FIELD_W-1:0]  ppr_in_map_t;
	typedef logic [PPR_PIN_COUNT-1:0][PPR_FIELD_W-1:0] ppr_out_map_t;

	typedef enum logic [1:0] {
		PPR_KEY_IDLE,
		PPR_KEY_ONE,
		PPR_KEY_TWO
	} ppr_key_t;

	typedef struct packed {
		ppr_key_t                key;
		logic                    lock;
		logic [PPR_DATA_W-1:0]   rdata;
	} ppr_ctrl_t;

	localparam ppr_ctrl_t PPR_CTRL_RST = '{key: PPR_KEY_IDLE, lock: PPR_LOCK_RST, rdata: 8'h00};

	typedef struct packed {
		ppr_in_map_t  in_map;
		ppr_in_map_t  in_shadow;
		ppr_out_map_t out_map;
		ppr_out_map_t out_shadow;
		logic         mismatch;
	} ppr_store_t;

	localparam ppr_store_t PPR_STORE_RST = '{
		in_map:     {PPR_IN_COUNT{PPR_IN_MAP_RST}},
		in_shadow:  {PPR_IN_COUNT{PPR_IN_MAP_RST}},
		out_map:    {PPR_PIN_COUNT{PPR_OUT_MAP_RST}},
		out_shadow: {PPR_PIN_COUNT{PPR_OUT_MAP_RST}},
		mismatch:   1'b0
	};

endpackage

// *** rtl/ppr_map_if.sv ***
/*
 * Carrier between the remap controller and the map storage.
 * Assumes both ends share ref_clk_i; no clocking blocks.
 */
`timescale 1ns/100ps
interface ppr_map_if;
	logic                               we;
	logic                               is_out;
	logic [ppr_pkg::PPR_FIELD_W-1:0]    idx;
	logic [ppr_pkg::PPR_FIELD_W-1:0]    data;
	ppr_pkg::ppr_in_map_t               in_map;
	ppr_pkg::ppr_out_map_t              out_map;
	logic                               mismatch;

	modport ctrl (output we, output is_out, output idx, output data,
		input in_map, input out_map, input mismatch);
	modport store (input we, input is_out, input idx, input data,
		output in_map, output out_map, output mismatch);
endinterface

// *** rtl/ppr_map_store.sv ***
/*
 * Input and output map fields with shadow copies and mismatch watch.
 * Assumes the controller only raises we when the map lock is clear.
 */
`timescale 1ns/100ps
module ppr_map_store (
	input  wire logic   ref_clk_i,
	input  wire logic   arst_n_i,
	ppr_map_if.store    m
);
	ppr_pkg::ppr_store_t st_r;
	ppr_pkg::ppr_store_t st_nxt;

	// legal writes land in field and shadow together
	always_comb begin
		st_nxt = st_r;
		if (m.we) begin
			if (m.is_out) begin
				if (m.idx < 5'(ppr_pkg::PPR_PIN_COUNT)) begin
					st_nxt.out_map[m.idx]    = m.data;
					st_nxt.out_shadow[m.idx] = m.data;
				end
			end else if (m.idx < 5'(ppr_pkg::PPR_IN_COUNT)) begin
				st_nxt.in_map[m.idx]    = m.data;
				st_nxt.in_shadow[m.idx] = m.data;
			end
		end
		// sticky until device reset: an upset must not be forgotten
		st_nxt.mismatch = st_r.mismatch | (st_r.in_map != st_r.in_shadow)
			| (st_r.out_map != st_r.out_shadow);
	end

	// reset leaves inputs tied low and outputs on port logic
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= ppr_pkg::PPR_STORE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign m.in_map   = st_r.in_map;
	assign m.out_map  = st_r.out_map;
	assign m.mismatch = st_r.mismatch;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	write_lands_a: assert property (
		m.we && !m.is_out && m.idx < 5'(ppr_pkg::PPR_IN_COUNT)
		|=> st_r.in_map[$past(m.idx)] == $past(m.data))
		else $error("input field write did not land");

	shadow_watch_a: assert property (
		(st_r.in_map != st_r.in_shadow) || (st_r.out_map != st_r.out_shadow)
		|=> m.mismatch [*2])
		else $error("shadow difference did not raise mismatch");
endmodule // ppr_map_store

// *** rtl/ppr_remap.sv ***
/*
 * Peripheral pin remap fabric: input and output muxes, map lock with
 * two-key sequence, one-way lock option, mismatch reset request.
 * Assumes all ports are synchronous to ref_clk_i (20 MHz).
 */
// How it works
// - each peripheral input has a 5-bit field; value n below 26 picks pin n.
// - input and output maps are separate fields with no cross limits.
// - a mapped pin feeds its peripheral only while its direction bit is 1.
// - nineteen peripheral inputs, interrupts through SPI select, each with a field.
// - each pin has a 5-bit field choosing the peripheral output that drives it.
// - output code zero leaves the pin with its default port logic.
// - codes 3,4,7,8,9 pick UART transmit, RTS, SPI data, clock, select.
// - codes 18,19,26 pick compare one, compare two, encoder direction.
// - with the lock set, map writes complete but change nothing.
// - the lock is bit 6 of the oscillator control low byte.
// - the lock holds its value until the key sequence changes it.
// - shadow copies are compared always; a difference requests a reset.
// - with the one-way option, a set lock stays set until reset.
// - option input high means one-way; low allows repeated sessions.
// - input fields reset to 11111, which ties the input low.
`timescale 1ns/100ps
module ppr_remap (
	input  wire logic                              ref_clk_i,
	input  wire logic                              arst_n_i,
	input  wire logic                              bus_wr_i,
	input  wire logic                              bus_rd_i,
	input  wire logic [ppr_pkg::PPR_ADDR_W-1:0]    bus_addr_i,
	input  wire logic [ppr_pkg::PPR_DATA_W-1:0]    bus_wdata_i,
	output      logic [ppr_pkg::PPR_DATA_W-1:0]    bus_rdata_o,
	input  wire logic                              one_way_lock_option_i,
	output      logic                              map_lock_bit_o,
	output      logic                              cfg_mismatch_rst_o,
	input  wire logic [ppr_pkg::PPR_PIN_COUNT-1:0] pin_in_i,
	input  wire logic [ppr_pkg::PPR_PIN_COUNT-1:0] pin_direction_reg_i,
	input  wire logic [ppr_pkg::PPR_PIN_COUNT-1:0] port_out_i,
	input  wire logic [ppr_pkg::PPR_PIN_COUNT-1:0] port_oe_i,
	output      logic [ppr_pkg::PPR_PIN_COUNT-1:0] pin_out_o,
	output      logic [ppr_pkg::PPR_PIN_COUNT-1:0] pin_oe_o,
	output      logic [ppr_pkg::PPR_IN_COUNT-1:0]  periph_in_o,
	input  wire logic                              uart_transmit_out_i,
	input  wire logic                              uart_request_to_send_out_i,
	input  wire logic                              spi_data_out_i,
	input  wire logic                              spi_clock_out_i,
	input  wire logic                              spi_select_out_i,
	input  wire logic                              compare_out_one_i,
	input  wire logic                              compare_out_two_i,
	input  wire logic                              encoder_direction_status_i
);
	ppr_map_if m ();

	ppr_pkg::ppr_ctrl_t                     c_r;
	ppr_pkg::ppr_ctrl_t                     c_nxt;
	logic                                   osc_hit;
	logic                                   in_hit;
	logic                                   out_hit;
	logic [ppr_pkg::PPR_FIELD_W-1:0]        in_idx;
	logic [ppr_pkg::PPR_FIELD_W-1:0]        out_idx;
	logic [ppr_pkg::PPR_SRC_COUNT-1:0]      src;

	ppr_map_store u_store (
		.ref_clk_i (ref_clk_i),
		.arst_n_i  (arst_n_i),
		.m         (m)
	);

	// returns {selected, level}; unlisted codes fall back to port logic
	function automatic logic [1:0] out_pick(input logic [ppr_pkg::PPR_FIELD_W-1:0] code,
		input logic [ppr_pkg::PPR_SRC_COUNT-1:0] s);
		case (code)
			ppr_pkg::PPR_OUT_U_TX:    out_pick = {1'b1, s[ppr_pkg::PPR_SRC_U_TX]};
			ppr_pkg::PPR_OUT_U_RTS:   out_pick = {1'b1, s[ppr_pkg::PPR_SRC_U_RTS]};
			ppr_pkg::PPR_OUT_SPI_DO:  out_pick = {1'b1, s[ppr_pkg::PPR_SRC_SPI_DO]};
			ppr_pkg::PPR_OUT_SPI_CK:  out_pick = {1'b1, s[ppr_pkg::PPR_SRC_SPI_CK]};
			ppr_pkg::PPR_OUT_SPI_SS:  out_pick = {1'b1, s[ppr_pkg::PPR_SRC_SPI_SS]};
			ppr_pkg::PPR_OUT_CMP1:    out_pick = {1'b1, s[ppr_pkg::PPR_SRC_CMP1]};
			ppr_pkg::PPR_OUT_CMP2:    out_pick = {1'b1, s[ppr_pkg::PPR_SRC_CMP2]};
			ppr_pkg::PPR_OUT_ENC_DIR: out_pick = {1'b1, s[ppr_pkg::PPR_SRC_ENC_DIR]};
			default:                  out_pick = 2'h0;
		endcase
	endfunction

	// tie-low and out-of-range codes deliver ground
	function automatic logic in_pick(input logic [ppr_pkg::PPR_FIELD_W-1:0] code,
		input logic [ppr_pkg::PPR_PIN_COUNT-1:0] pins,
		input logic [ppr_pkg::PPR_PIN_COUNT-1:0] dir);
		if (code < 5'(ppr_pkg::PPR_PIN_COUNT)) begin
			in_pick = pins[code] & dir[code];
		end else begin
			in_pick = 1'b0;
		end
	endfunction

	assign src = {encoder_direction_status_i, compare_out_two_i, compare_out_one_i,
		spi_select_out_i, spi_clock_out_i, spi_data_out_i,
		uart_request_to_send_out_i, uart_transmit_out_i};

	// input muxes: one per peripheral, independent of the output muxes
	generate
		for (genvar k = 0; k < ppr_pkg::PPR_IN_COUNT; k++) begin : g_in
			assign periph_in_o[k] = in_pick(m.in_map[k], pin_in_i, pin_direction_reg_i);
		end
		for (genvar p = 0; p < ppr_pkg::PPR_PIN_COUNT; p++) begin : g_out
			logic [1:0] pick;
			assign pick = out_pick(m.out_map[p], src);
			// peripheral owns the pin while selected, else port logic does
			assign pin_out_o[p] = pick[1] ? pick[0] : port_out_i[p];
			assign pin_oe_o[p]  = pick[1] ? 1'b1 : port_oe_i[p];
		end
	endgenerate

	// address decode
	always_comb begin
		osc_hit = 1'b0;
		in_hit  = 1'b0;
		out_hit = 1'b0;
		in_idx  = 5'(bus_addr_i - ppr_pkg::PPR_ADDR_IN_BASE);
		out_idx = 5'(bus_addr_i - ppr_pkg::PPR_ADDR_OUT_BASE);
		if (bus_addr_i == ppr_pkg::PPR_ADDR_OSC) begin
			osc_hit = 1'b1;
		end else if (bus_addr_i >= ppr_pkg::PPR_ADDR_IN_BASE
			&& bus_addr_i < ppr_pkg::PPR_ADDR_IN_BASE + 7'(ppr_pkg::PPR_IN_COUNT)) begin
			in_hit = 1'b1;
		end else if (bus_addr_i >= ppr_pkg::PPR_ADDR_OUT_BASE
			&& bus_addr_i < ppr_pkg::PPR_ADDR_OUT_BASE + 7'(ppr_pkg::PPR_PIN_COUNT)) begin
			out_hit = 1'b1;
		end
	end

	// key sequence, lock, map write gating and read data
	always_comb begin
		c_nxt    = c_r;
		m.we     = bus_wr_i && (in_hit || out_hit) && !c_r.lock;
		m.is_out = out_hit;
		m.idx    = out_hit ? out_idx : in_idx;
		m.data   = bus_wdata_i[ppr_pkg::PPR_FIELD_W-1:0];
		if (bus_wr_i && osc_hit) begin
			case (c_r.key)
				ppr_pkg::PPR_KEY_IDLE: begin
					c_nxt.key = (bus_wdata_i == ppr_pkg::PPR_KEY_FIRST)
						? ppr_pkg::PPR_KEY_ONE : ppr_pkg::PPR_KEY_IDLE;
				end
				ppr_pkg::PPR_KEY_ONE: begin
					if (bus_wdata_i == ppr_pkg::PPR_KEY_SECOND) begin
						c_nxt.key = ppr_pkg::PPR_KEY_TWO;
					end else if (bus_wdata_i == ppr_pkg::PPR_KEY_FIRST) begin
						c_nxt.key = ppr_pkg::PPR_KEY_ONE;
					end else begin
						c_nxt.key = ppr_pkg::PPR_KEY_IDLE;
					end
				end
				ppr_pkg::PPR_KEY_TWO: begin
					// one-way option: a set lock refuses to clear
					if (!(one_way_lock_option_i && c_r.lock)) begin
						c_nxt.lock = bus_wdata_i[ppr_pkg::PPR_LOCK_BIT];
					end
					c_nxt.key = ppr_pkg::PPR_KEY_IDLE;
				end
				default: c_nxt.key = ppr_pkg::PPR_KEY_IDLE;
			endcase
		end else if (bus_wr_i || bus_rd_i) begin
			c_nxt.key = ppr_pkg::PPR_KEY_IDLE;
		end
		if (bus_rd_i) begin
			c_nxt.rdata = 8'h00;
			if (osc_hit) begin
				c_nxt.rdata[ppr_pkg::PPR_LOCK_BIT] = c_r.lock;
			end else if (in_hit) begin
				c_nxt.rdata = {3'h0, m.in_map[in_idx]};
			end else if (out_hit) begin
				c_nxt.rdata = {3'h0, m.out_map[out_idx]};
			end
		end
	end

	// lock holds across any number of map writes until changed
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			c_r <= ppr_pkg::PPR_CTRL_RST;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign bus_rdata_o        = c_r.rdata;
	assign map_lock_bit_o     = c_r.lock;
	assign cfg_mismatch_rst_o = m.mismatch;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence key_one_s;
		bus_wr_i && osc_hit && bus_wdata_i == ppr_pkg::PPR_KEY_FIRST;
	endsequence
	sequence key_two_s;
		bus_wr_i && osc_hit && bus_wdata_i == ppr_pkg::PPR_KEY_SECOND;
	endsequence

	// strobes are single-cycle pulses with an idle cycle between accesses
	key_unlock_a: assert property (
		((c_r.key == ppr_pkg::PPR_KEY_IDLE) and key_one_s) ##2 key_two_s
		##2 (c_r.key == ppr_pkg::PPR_KEY_TWO && bus_wr_i && osc_hit
		&& !bus_wdata_i[ppr_pkg::PPR_LOCK_BIT] && !one_way_lock_option_i)
		|=> !map_lock_bit_o)
		else $error("key sequence did not clear the lock");

	key_abort_a: assert property (
		(c_r.key == ppr_pkg::PPR_KEY_ONE && bus_rd_i && !bus_wr_i) ##1 !bus_wr_i
		##1 key_two_s ##1 !bus_wr_i ##1 (bus_wr_i && osc_hit)
		|=> $stable(map_lock_bit_o))
		else $error("interrupted key sequence changed the lock");

	one_way_hold_a: assert property (
		one_way_lock_option_i && map_lock_bit_o |=> map_lock_bit_o)
		else $error("one-way lock was cleared");

	lock_stable_a: assert property (
		!(bus_wr_i && osc_hit && c_r.key == ppr_pkg::PPR_KEY_TWO)
		|=> $stable(map_lock_bit_o))
		else $error("lock changed without the key sequence");

	locked_write_a: assert property (
		bus_wr_i && (in_hit || out_hit) && map_lock_bit_o
		|=> $stable(m.in_map) && $stable(m.out_map))
		else $error("map changed while locked");

	generate
		for (genvar a = 0; a < ppr_pkg::PPR_IN_COUNT; a++) begin : g_in_chk
			dir_gate_a: assert property (
				m.in_map[a] < 5'(ppr_pkg::PPR_PIN_COUNT)
				&& !pin_direction_reg_i[m.in_map[a]] |-> !periph_in_o[a])
				else $error("output-direction pin reached a peripheral");
			tie_ground_a: assert property (
				m.in_map[a] == ppr_pkg::PPR_IN_TIE_GND |-> !periph_in_o[a])
				else $error("tied-low input not low");
		end
		for (genvar b = 0; b < ppr_pkg::PPR_PIN_COUNT; b++) begin : g_out_chk
			null_code_a: assert property (
				m.out_map[b] == ppr_pkg::PPR_OUT_NULL
				|-> pin_out_o[b] == port_out_i[b] && pin_oe_o[b] == port_oe_i[b])
				else $error("null code did not leave port logic");
			uart_code_a: assert property (
				m.out_map[b] == ppr_pkg::PPR_OUT_U_TX
				|-> pin_out_o[b] == uart_transmit_out_i && pin_oe_o[b])
				else $error("uart transmit not on pin");
			enc_code_a: assert property (
				m.out_map[b] == ppr_pkg::PPR_OUT_ENC_DIR
				|-> pin_out_o[b] == encoder_direction_status_i && pin_oe_o[b])
				else $error("encoder direction not on pin");
		end
	endgenerate
endmodule // ppr_remap

// *** tb/ppr_periph_model.sv ***
/*
 * Far-side model: remappable pin levels, direction bits, default port
 * drive and the peripheral output levels. Assumes one clock, ref_clk_i.
 */
`timescale 1ns/100ps
module ppr_periph_model (
	input  wire logic                              ref_clk_i,
	input  wire logic                              arst_n_i,
	output      logic [ppr_pkg::PPR_PIN_COUNT-1:0] pin_o,
	output      logic [ppr_pkg::PPR_PIN_COUNT-1:0] dir_o,
	output      logic [ppr_pkg::PPR_PIN_COUNT-1:0] port_out_o,
	output      logic [ppr_pkg::PPR_PIN_COUNT-1:0] port_oe_o,
	output      logic [ppr_pkg::PPR_SRC_COUNT-1:0] src_o
);
	// alternate directions so mapped inputs meet both input and output pins
	assign dir_o      = 26'h2aa_aaaa;
	assign port_oe_o  = ~dir_o;
	assign port_out_o = ~pin_o;

	// levels move every cycle, so a stale or wrong mux leg shows quickly
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_o <= 26'h000_0000;
			src_o <= 8'h00;
		end else begin
			pin_o <= {pin_o[24:0], ~pin_o[25]};
			src_o <= {src_o[6:0], ~src_o[7]};
		end
	end
endmodule // ppr_periph_model

// *** tb/ppr_remap_test.sv ***
/*
 * Self-checking bench for the pin remap fabric: key sequence, lock,
 * input and output maps. Assumes the far-side model in ppr_periph_model.
 */
`timescale 1ns/100ps
module ppr_remap_test;
	logic                              ref_clk_i;
	logic                              arst_n_i;
	logic                              bus_wr;
	logic                              bus_rd;
	logic                              one_way;
	logic [ppr_pkg::PPR_ADDR_W-1:0]    addr;
	logic [ppr_pkg::PPR_DATA_W-1:0]    wdata;
	logic [ppr_pkg::PPR_DATA_W-1:0]    rdata;
	logic                              lock;
	logic                              mism;
	logic [ppr_pkg::PPR_PIN_COUNT-1:0] pin, dir, pout, poe, pin_out, pin_oe;
	logic [ppr_pkg::PPR_IN_COUNT-1:0]  periph_in;
	logic [ppr_pkg::PPR_SRC_COUNT-1:0] src;
	logic [4:0]                        fld [19];
	logic [4:0]                        ofld [26];
	logic [4:0]                        codes [8];
	logic                              exp_lock;
	int                                err_count;
	int                                comparisons;

	ppr_periph_model far (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pin_o(pin), .dir_o(dir),
		.port_out_o(pout), .port_oe_o(poe), .src_o(src));

	ppr_remap dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .bus_wr_i(bus_wr),
		.bus_rd_i(bus_rd), .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
		.one_way_lock_option_i(one_way), .map_lock_bit_o(lock), .cfg_mismatch_rst_o(mism),
		.pin_in_i(pin), .pin_direction_reg_i(dir), .port_out_i(pout), .port_oe_i(poe),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe), .periph_in_o(periph_in),
		.uart_transmit_out_i(src[0]), .uart_request_to_send_out_i(src[1]),
		.spi_data_out_i(src[2]), .spi_clock_out_i(src[3]), .spi_select_out_i(src[4]),
		.compare_out_one_i(src[5]), .compare_out_two_i(src[6]),
		.encoder_direction_status_i(src[7]));

	// 20 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp_sig(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	// one write: strobe held for exactly the edge that takes it
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		bus_wr <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge ref_clk_i);
		bus_wr <= 1'b0;
	endtask

	// read data lands on the take edge, so sample it half a cycle later
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i);
		bus_rd <= 1'b1;
		addr   <= a;
		@(posedge ref_clk_i);
		bus_rd <= 1'b0;
		@(negedge ref_clk_i);
		cmp_reg(rdata, exp);
	endtask

	task automatic key_seq(input logic [7:0] v);
		wr(7'h00, 8'h46);
		wr(7'h00, 8'h57);
		wr(7'h00, v);
	endtask

	// all mux outputs and status against the fields the bench believes in
	task automatic chk();
		logic [18:0] ei;
		logic [25:0] eo;
		logic [25:0] ee;
		@(negedge ref_clk_i);
		for (int k = 0; k < 19; k++) begin
			ei[k] = (fld[k] < 5'h1a) ? (pin[fld[k]] & dir[fld[k]]) : 1'b0;
		end
		for (int p = 0; p < 26; p++) begin
			eo[p] = pout[p];
			ee[p] = poe[p];
			for (int i = 0; i < 8; i++) begin
				if (ofld[p] == codes[i]) begin
					eo[p] = src[i];
					ee[p] = 1'b1;
				end
			end
		end
		cmp_sig(32'(periph_in), 32'(ei));
		cmp_sig(32'(pin_out), 32'(eo));
		cmp_sig(32'(pin_oe), 32'(ee));
		cmp_sig(32'(lock), 32'(exp_lock));
		cmp_sig(32'(mism), 32'h0000_0000);
	endtask

	task automatic do_reset();
		@(posedge ref_clk_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		exp_lock = 1'b0;
		for (int k = 0; k < 19; k++) fld[k] = 5'h1f;
		for (int p = 0; p < 26; p++) ofld[p] = 5'h00;
	endtask

	// a hang ends the run as a failure
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_count++;
		$display("timeout at %0t", $time);
		close_out();
	end

	initial begin
		arst_n_i    = 1'b0;
		bus_wr      = 1'b0;
		bus_rd      = 1'b0;
		addr        = 7'h00;
		wdata       = 8'h00;
		one_way     = 1'b0;
		err_count   = 0;
		comparisons = 0;
		codes = '{ppr_pkg::PPR_OUT_U_TX, ppr_pkg::PPR_OUT_U_RTS, ppr_pkg::PPR_OUT_SPI_DO,
			ppr_pkg::PPR_OUT_SPI_CK, ppr_pkg::PPR_OUT_SPI_SS, ppr_pkg::PPR_OUT_CMP1,
			ppr_pkg::PPR_OUT_CMP2, ppr_pkg::PPR_OUT_ENC_DIR};
		do_reset();
		chk();
		rd(7'h20, 8'h1f);
		rd(7'h00, 8'h00);
		// lock, then map writes must be dropped
		key_seq(8'h40);
		exp_lock = 1'b1;
		chk();
		rd(7'h00, 8'h40);
		wr(7'h20, 8'h01);
		wr(7'h40, 8'h03);
		chk();
		rd(7'h20, 8'h1f);
		// option off: a second session is allowed and lock holds meanwhile
		key_seq(8'h00);
		exp_lock = 1'b0;
		chk();
		for (int k = 0; k < 19; k++) begin
			wr(7'h20 + 7'(k), 8'(k + 7));
			fld[k] = 5'(k + 7);
			chk();
			rd(7'h20 + 7'(k), 8'(k + 7));
		end
		// every output code on one pin, then null
		for (int i = 0; i < 8; i++) begin
			wr(7'h42, {3'b000, codes[i]});
			ofld[2] = codes[i];
			chk();
			chk();
		end
		wr(7'h42, 8'h00);
		ofld[2] = 5'h00;
		chk();
		// pin 7 carries an output while peripheral input 0 still reads it
		wr(7'h47, 8'h08);
		ofld[7] = 5'h08;
		wr(7'h43, 8'h01);
		ofld[3] = 5'h01;
		chk();
		// interrupted key sequences must not move the lock
		wr(7'h00, 8'h46);
		rd(7'h00, 8'h00);
		wr(7'h00, 8'h57);
		wr(7'h00, 8'h40);
		chk();
		wr(7'h00, 8'h46);
		wr(7'h7f, 8'h00);
		wr(7'h00, 8'h57);
		wr(7'h00, 8'h40);
		chk();
		rd(7'h7f, 8'h00);
		// one-way option: once set, the lock survives a clear attempt
		@(posedge ref_clk_i);
		one_way <= 1'b1;
		key_seq(8'h40);
		exp_lock = 1'b1;
		chk();
		key_seq(8'h00);
		chk();
		wr(7'h20, 8'h02);
		chk();
		// only a reset reopens the map, and it restores every field
		do_reset();
		chk();
		key_seq(8'h40);
		exp_lock = 1'b1;
		chk();
		close_out();
	end
endmodule // ppr_remap_test
